// File: src/ehs_strap_config.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ehs_cfg.svh"
// What this block does
// - Mode pins select hardware, serial or parallel interface.
// - Termination pin picks external or internal matching.
// - Path mode: HDB3, AMI, dual rail recovery, slicer.
// - Template pin picks 75 or 120 ohm.
// - Receiver power down pin high powers receiver down.
// - Pattern pins: normal, all ones, PRBS, transmitter off.
// - Jitter pins: off, rx broad, rx narrow, tx.
// - Monitor gain pin picks 0 dB or 26 dB.
// - Loopback pins: none, analog, digital, remote.
// - Driver high impedance pin high disables driver.
// - Edge pin picks rising or falling receive clock.
module ehs_strap_config (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [1:0] MODE_SELECT,
    input wire logic TERMINATION_SELECT,
    input wire logic [1:0] PATH_CODING_MODE_SELECT,
    input wire logic PULSE_TEMPLATE_SELECT,
    input wire logic RECEIVER_POWER_DOWN,
    input wire logic [1:0] TRANSMIT_TEST_PATTERN_SELECT,
    input wire logic [1:0] JITTER_ATTENUATOR_CONFIG,
    input wire logic MONITOR_GAIN_SELECT,
    input wire logic [1:0] LOOPBACK_SELECT,
    input wire logic DRIVER_HIGH_IMPEDANCE,
    input wire logic RECEIVE_CLOCK_EDGE_SELECT,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WR_DATA,
    input wire logic WR_STROBE,
    input wire logic RD_STROBE,
    output logic [31:0] RD_DATA,
    output logic IF_HARDWARE,
    output logic IF_SERIAL,
    output logic IF_PARALLEL_A,
    output logic IF_PARALLEL_B,
    output logic TERM_INTERNAL,
    output logic PATH_SINGLE_RAIL,
    output logic PATH_HDB3,
    output logic PATH_CLOCK_RECOVERY,
    output logic PATH_SLICER,
    output logic TEMPLATE_120_OHM,
    output logic RX_POWERED_DOWN,
    output logic TX_SEND_ALL_ONES,
    output logic TX_SEND_PRBS,
    output logic TX_POWERED_DOWN,
    output logic JITTER_ENABLE,
    output logic JITTER_IN_TX_PATH,
    output logic JITTER_NARROW_BW,
    output logic [7:0] JITTER_FIFO_DEPTH,
    output logic MONITOR_GAIN_HIGH,
    output logic LOOP_ANALOG,
    output logic LOOP_DIGITAL,
    output logic LOOP_REMOTE,
    output logic TX_DRIVER_ENABLE,
    output logic RX_CLK_FALLING
);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic [15:0] pin_raw;
    logic [15:0] pin_meta;
    logic [15:0] pin_sync;

    assign pin_raw = {MODE_SELECT, RECEIVE_CLOCK_EDGE_SELECT, DRIVER_HIGH_IMPEDANCE, LOOPBACK_SELECT,
                      MONITOR_GAIN_SELECT, JITTER_ATTENUATOR_CONFIG, TRANSMIT_TEST_PATTERN_SELECT,
                      RECEIVER_POWER_DOWN, PULSE_TEMPLATE_SELECT, TERMINATION_SELECT,
                      PATH_CODING_MODE_SELECT};

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            pin_meta <= 16'h0000;
            pin_sync <= 16'h0000;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire [`EHS_CFG_W-1:0] pin_cfg = pin_sync[`EHS_CFG_W-1:0];
    wire [1:0] mode_sync = pin_sync[15:14];

    // ------------------------------------------------------------------
    // Register bus.
    // ------------------------------------------------------------------
    logic [`EHS_CFG_W-1:0] ctrl;
    logic strap_changed;
    logic [`EHS_CFG_W-1:0] pin_cfg_prev;
    logic [1:0] settle;
    logic [31:0] next_rd_data;

    wire hit_ctrl = (ADDR == `EHS_OFF_CTRL);
    wire hit_status = (ADDR == `EHS_OFF_STATUS);
    wire hit_strap = (ADDR == `EHS_OFF_STRAP);
    wire wr_ctrl = WR_STROBE && hit_ctrl;
    wire clr_changed = WR_STROBE && hit_status && WR_DATA[`EHS_S_CHANGED];
    wire settled = (settle == `EHS_SETTLE_CYCLES);
    wire strap_moved = settled && (pin_cfg != pin_cfg_prev);

    // ------------------------------------------------------------------
    // Source selection and decode.
    // ------------------------------------------------------------------
    ehs_pkg::ehs_if_mode_type if_mode;
    ehs_pkg::ehs_path_mode_type path_mode;
    ehs_pkg::ehs_pattern_type pattern;
    ehs_pkg::ehs_jitter_type jitter;
    ehs_pkg::ehs_loop_type loop;

    assign if_mode = ehs_pkg::ehs_if_mode_type'(mode_sync);
    wire hw_mode = (if_mode == ehs_pkg::EHS_IF_HARDWARE);
    wire [`EHS_CFG_W-1:0] cfg = hw_mode ? pin_cfg : ctrl;

    assign path_mode = ehs_pkg::ehs_path_mode_type'(cfg[`EHS_F_PATH_LO +: 2]);
    assign pattern = ehs_pkg::ehs_pattern_type'(cfg[`EHS_F_PATTERN_LO +: 2]);
    assign jitter = ehs_pkg::ehs_jitter_type'(cfg[`EHS_F_JIT_LO +: 2]);
    assign loop = ehs_pkg::ehs_loop_type'(cfg[`EHS_F_LOOP_LO +: 2]);

    logic [7:0] next_fifo_depth;

    always_comb begin
        case (jitter)
            ehs_pkg::EHS_JIT_RX_BROAD: next_fifo_depth = `EHS_FIFO_BROAD;
            ehs_pkg::EHS_JIT_RX_NARROW: next_fifo_depth = `EHS_FIFO_NARROW;
            ehs_pkg::EHS_JIT_TX_NARROW: next_fifo_depth = `EHS_FIFO_NARROW;
            default: next_fifo_depth = 8'h00;
        endcase
    end

    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (RD_STROBE && hit_ctrl) begin
            next_rd_data[`EHS_CFG_W-1:0] = ctrl;
        end else if (RD_STROBE && hit_status) begin
            next_rd_data[`EHS_S_MODE_LO +: 2] = mode_sync;
            next_rd_data[`EHS_S_HW] = hw_mode;
            next_rd_data[`EHS_S_CHANGED] = strap_changed;
            next_rd_data[`EHS_S_CFG_LO +: `EHS_CFG_W] = cfg;
        end else if (RD_STROBE && hit_strap) begin
            next_rd_data[15:0] = pin_sync;
        end
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ctrl <= `EHS_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= WR_DATA[`EHS_CFG_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            settle <= 2'h0;
            pin_cfg_prev <= `EHS_CFG_RESET;
            strap_changed <= 1'b0;
        end else begin
            settle <= settled ? settle : settle + 2'h1;
            pin_cfg_prev <= pin_cfg;
            if (strap_moved && hw_mode) begin
                strap_changed <= 1'b1;
            end else if (clr_changed) begin
                strap_changed <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            RD_DATA <= 32'h0000_0000;
        end else begin
            RD_DATA <= next_rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Decoded outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            IF_HARDWARE <= 1'b0;
            IF_SERIAL <= 1'b0;
            IF_PARALLEL_A <= 1'b0;
            IF_PARALLEL_B <= 1'b0;
        end else begin
            IF_HARDWARE <= (if_mode == ehs_pkg::EHS_IF_HARDWARE);
            IF_SERIAL <= (if_mode == ehs_pkg::EHS_IF_SERIAL);
            IF_PARALLEL_A <= (if_mode == ehs_pkg::EHS_IF_PARALLEL_A);
            IF_PARALLEL_B <= (if_mode == ehs_pkg::EHS_IF_PARALLEL_B);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            TERM_INTERNAL <= 1'b0;
            PATH_SINGLE_RAIL <= 1'b0;
            PATH_HDB3 <= 1'b0;
            PATH_CLOCK_RECOVERY <= 1'b0;
            PATH_SLICER <= 1'b0;
            TEMPLATE_120_OHM <= 1'b0;
            RX_POWERED_DOWN <= 1'b0;
            MONITOR_GAIN_HIGH <= 1'b0;
            RX_CLK_FALLING <= 1'b0;
        end else begin
            TERM_INTERNAL <= cfg[`EHS_F_TERM];
            PATH_SINGLE_RAIL <= (path_mode == ehs_pkg::EHS_PATH_SINGLE_HDB3) ||
                                (path_mode == ehs_pkg::EHS_PATH_SINGLE_AMI);
            PATH_HDB3 <= (path_mode == ehs_pkg::EHS_PATH_SINGLE_HDB3);
            PATH_CLOCK_RECOVERY <= (path_mode == ehs_pkg::EHS_PATH_DUAL_RECOVERY);
            PATH_SLICER <= (path_mode == ehs_pkg::EHS_PATH_SLICER);
            TEMPLATE_120_OHM <= cfg[`EHS_F_PULSE];
            RX_POWERED_DOWN <= cfg[`EHS_F_RX_DOWN];
            MONITOR_GAIN_HIGH <= cfg[`EHS_F_MON];
            RX_CLK_FALLING <= cfg[`EHS_F_RCLK];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            TX_SEND_ALL_ONES <= 1'b0;
            TX_SEND_PRBS <= 1'b0;
            TX_POWERED_DOWN <= 1'b0;
            JITTER_ENABLE <= 1'b0;
            JITTER_IN_TX_PATH <= 1'b0;
            JITTER_NARROW_BW <= 1'b0;
            JITTER_FIFO_DEPTH <= 8'h00;
        end else begin
            TX_SEND_ALL_ONES <= (pattern == ehs_pkg::EHS_PATTERN_ALL_ONES);
            TX_SEND_PRBS <= (pattern == ehs_pkg::EHS_PATTERN_PRBS);
            TX_POWERED_DOWN <= (pattern == ehs_pkg::EHS_PATTERN_TX_OFF);
            JITTER_ENABLE <= (jitter != ehs_pkg::EHS_JIT_OFF);
            JITTER_IN_TX_PATH <= (jitter == ehs_pkg::EHS_JIT_TX_NARROW);
            JITTER_NARROW_BW <= (jitter == ehs_pkg::EHS_JIT_RX_NARROW) ||
                                (jitter == ehs_pkg::EHS_JIT_TX_NARROW);
            JITTER_FIFO_DEPTH <= next_fifo_depth;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            LOOP_ANALOG <= 1'b0;
            LOOP_DIGITAL <= 1'b0;
            LOOP_REMOTE <= 1'b0;
            TX_DRIVER_ENABLE <= 1'b0;
        end else begin
            LOOP_ANALOG <= (loop == ehs_pkg::EHS_LOOP_ANALOG);
            LOOP_DIGITAL <= (loop == ehs_pkg::EHS_LOOP_DIGITAL);
            LOOP_REMOTE <= (loop == ehs_pkg::EHS_LOOP_REMOTE);
            TX_DRIVER_ENABLE <= !cfg[`EHS_F_HIZ];
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking ast_clk @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    AST_IF_MODE: assert property ($past(RSTN) && $past(RSTN, 2) && $past(RSTN, 3) &&
        $past(MODE_SELECT == 2'b01, 3) |-> IF_SERIAL && !IF_HARDWARE)
        else $error("Serial interface not decoded from mode pins.");

    AST_IF_ONEHOT: assert property ($past(RSTN) |->
        $onehot({IF_HARDWARE, IF_SERIAL, IF_PARALLEL_A, IF_PARALLEL_B}))
        else $error("Interface mode outputs not one-hot.");

    AST_TERM: assert property ($past(RSTN) && $past(hw_mode) |->
        TERM_INTERNAL == $past(pin_sync[`EHS_F_TERM]))
        else $error("Termination output does not follow its pin.");

    AST_PATH: assert property ($past(RSTN) |->
        (PATH_HDB3 == ($past(path_mode) == ehs_pkg::EHS_PATH_SINGLE_HDB3)) &&
        (PATH_SINGLE_RAIL == !$past(cfg[1])))
        else $error("Path mode decode wrong.");

    AST_PULSE: assert property ($past(RSTN) && $past(hw_mode) |->
        TEMPLATE_120_OHM == $past(pin_sync[`EHS_F_PULSE]))
        else $error("Template select does not follow its pin.");

    AST_RX_DOWN: assert property ($past(RSTN) && $past(hw_mode) |->
        RX_POWERED_DOWN == $past(pin_sync[`EHS_F_RX_DOWN]))
        else $error("Receiver power down does not follow its pin.");

    AST_PATTERN: assert property ($past(RSTN) && $past(hw_mode) && $past(pin_sync[6:5] == 2'b11) |->
        TX_POWERED_DOWN && !TX_SEND_PRBS && !TX_SEND_ALL_ONES)
        else $error("Transmitter power down pattern not decoded.");

    AST_JIT: assert property ($past(RSTN) && $past(jitter == ehs_pkg::EHS_JIT_RX_BROAD) |->
        JITTER_ENABLE && !JITTER_NARROW_BW && !JITTER_IN_TX_PATH && JITTER_FIFO_DEPTH == 8'h40)
        else $error("Broad receive jitter setting wrong.");

    AST_JIT_NARROW: assert property ($past(RSTN) && $past(jitter == ehs_pkg::EHS_JIT_RX_NARROW) |->
        JITTER_ENABLE && JITTER_NARROW_BW && !JITTER_IN_TX_PATH && JITTER_FIFO_DEPTH == `EHS_FIFO_NARROW)
        else $error("Narrow receive jitter setting wrong.");

    AST_MON: assert property ($past(RSTN) |-> MONITOR_GAIN_HIGH == $past(cfg[`EHS_F_MON]))
        else $error("Monitor gain does not follow its setting.");

    AST_LOOP: assert property ($past(RSTN) |->
        $onehot0({LOOP_ANALOG, LOOP_DIGITAL, LOOP_REMOTE}) &&
        (LOOP_REMOTE == ($past(loop) == ehs_pkg::EHS_LOOP_REMOTE)))
        else $error("Loopback decode wrong.");

    AST_HIZ: assert property (RSTN && $past(RSTN) && $past(hw_mode) && $past(pin_sync[`EHS_F_HIZ]) |->
        !TX_DRIVER_ENABLE)
        else $error("Driver enabled while high impedance pin is high.");

    AST_DRV_ON: assert property ($past(RSTN) && $past(hw_mode) && !$past(pin_sync[`EHS_F_HIZ]) |->
        TX_DRIVER_ENABLE)
        else $error("Driver disabled while high impedance pin is low.");

    AST_RCLK: assert property ($past(RSTN) |-> RX_CLK_FALLING == $past(cfg[`EHS_F_RCLK]))
        else $error("Receive clock edge select wrong.");

    AST_SW_SOURCE: assert property (!hw_mode && wr_ctrl ##1 !hw_mode |->
        ##1 TERM_INTERNAL == $past(WR_DATA[`EHS_F_TERM], 2))
        else $error("Software setting not applied outside hardware mode.");

    AST_CHANGED: assert property (strap_moved && hw_mode |=> strap_changed)
        else $error("Strap change not flagged.");

    AST_SW_QUIET: assert property (strap_moved && !hw_mode && !strap_changed |=> !strap_changed)
        else $error("Strap change flagged outside hardware mode.");

    AST_CLR: assert property (clr_changed && !(strap_moved && hw_mode) |=> !strap_changed)
        else $error("Strap change flag not cleared.");

    AST_RD_STRAP: assert property (RD_STROBE && hit_strap |=> RD_DATA[15:0] == $past(pin_sync))
        else $error("Strap read data wrong.");

    AST_RD_ONE: assert property (!RD_STROBE |=> RD_DATA == 32'h0000_0000)
        else $error("Read data present without a read.");

    COV_HW: cover property (IF_HARDWARE ##1 LOOP_REMOTE);
    COV_SW: cover property (wr_ctrl && !hw_mode ##2 TX_SEND_PRBS);
    COV_CHANGE: cover property (strap_changed ##1 clr_changed);
    COV_PARALLEL: cover property ($rose(IF_PARALLEL_B));

endmodule

// File: src/ehs_cfg.svh
`ifndef EHS_CFG_SVH
`define EHS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define EHS_ADDR_W 8
`define EHS_OFF_CTRL 8'h00
`define EHS_OFF_STATUS 8'h04
`define EHS_OFF_STRAP 8'h08

// ----------------------------------------------------------------------
// Configuration word field positions, shared by control and strap views.
// ----------------------------------------------------------------------
`define EHS_CFG_W 14
`define EHS_F_PATH_LO 0
`define EHS_F_TERM 2
`define EHS_F_PULSE 3
`define EHS_F_RX_DOWN 4
`define EHS_F_PATTERN_LO 5
`define EHS_F_JIT_LO 7
`define EHS_F_MON 9
`define EHS_F_LOOP_LO 10
`define EHS_F_HIZ 12
`define EHS_F_RCLK 13

// ----------------------------------------------------------------------
// Status field positions.
// ----------------------------------------------------------------------
`define EHS_S_MODE_LO 0
`define EHS_S_HW 2
`define EHS_S_CHANGED 3
`define EHS_S_CFG_LO 4

// ----------------------------------------------------------------------
// Reset values and counts.
// ----------------------------------------------------------------------
`define EHS_CTRL_RESET 14'h1000
`define EHS_CFG_RESET 14'h1000
`define EHS_FIFO_BROAD 8'h40
`define EHS_FIFO_NARROW 8'h80
`define EHS_SETTLE_CYCLES 2'h3

`endif

// File: src/ehs_pkg.sv
package ehs_pkg;

    typedef enum logic [1:0] {
        EHS_IF_HARDWARE,
        EHS_IF_SERIAL,
        EHS_IF_PARALLEL_A,
        EHS_IF_PARALLEL_B
    } ehs_if_mode_type;

    typedef enum logic [1:0] {
        EHS_PATH_SINGLE_HDB3,
        EHS_PATH_SINGLE_AMI,
        EHS_PATH_DUAL_RECOVERY,
        EHS_PATH_SLICER
    } ehs_path_mode_type;

    typedef enum logic [1:0] {
        EHS_PATTERN_NORMAL,
        EHS_PATTERN_ALL_ONES,
        EHS_PATTERN_PRBS,
        EHS_PATTERN_TX_OFF
    } ehs_pattern_type;

    typedef enum logic [1:0] {
        EHS_JIT_OFF,
        EHS_JIT_RX_BROAD,
        EHS_JIT_RX_NARROW,
        EHS_JIT_TX_NARROW
    } ehs_jitter_type;

    typedef enum logic [1:0] {
        EHS_LOOP_NONE,
        EHS_LOOP_ANALOG,
        EHS_LOOP_DIGITAL,
        EHS_LOOP_REMOTE
    } ehs_loop_type;

endpackage

// File: dv/ehs_strap_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Board strapping model.
// ----------------------------------------------------------------------
// The pins other than mode select are held at the static levels of one word, as a strap would.
module ehs_strap_model (
    input wire logic [1:0] mode,
    input wire logic [13:0] word,
    output logic [1:0] mode_select,
    output logic termination_select,
    output logic [1:0] path_coding_mode_select,
    output logic pulse_template_select,
    output logic receiver_power_down,
    output logic [1:0] transmit_test_pattern_select,
    output logic [1:0] jitter_attenuator_config,
    output logic monitor_gain_select,
    output logic [1:0] loopback_select,
    output logic driver_high_impedance,
    output logic receive_clock_edge_select
);
    assign mode_select = mode;
    assign path_coding_mode_select = word[1:0];
    assign termination_select = word[2];
    assign pulse_template_select = word[3];
    assign receiver_power_down = word[4];
    assign transmit_test_pattern_select = word[6:5];
    assign jitter_attenuator_config = word[8:7];
    assign monitor_gain_select = word[9];
    assign loopback_select = word[11:10];
    assign driver_high_impedance = word[12];
    assign receive_clock_edge_select = word[13];
endmodule

// File: dv/ehs_strap_config_tb_top.sv
`timescale 1ns/1ps
module ehs_strap_config_tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [13:0] word = 14'h0000;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h00000000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [31:0] rd_data;
    logic [1:0] p_mode, p_path, p_pattern, p_jit, p_loop;
    logic p_term, p_pulse, p_rxpd, p_mon, p_hiz, p_rclk;
    wire [30:0] outs;
    logic [13:0] ctrl = 14'h1000;
    logic [13:0] c;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #4 ref_clk = ~ref_clk;

    ehs_strap_model strap (.mode(mode), .word(word), .mode_select(p_mode), .termination_select(p_term),
        .path_coding_mode_select(p_path), .pulse_template_select(p_pulse), .receiver_power_down(p_rxpd),
        .transmit_test_pattern_select(p_pattern), .jitter_attenuator_config(p_jit), .monitor_gain_select(p_mon),
        .loopback_select(p_loop), .driver_high_impedance(p_hiz), .receive_clock_edge_select(p_rclk));

    ehs_strap_config dut (.REF_CLK(ref_clk), .RSTN(rstn), .MODE_SELECT(p_mode), .TERMINATION_SELECT(p_term),
        .PATH_CODING_MODE_SELECT(p_path), .PULSE_TEMPLATE_SELECT(p_pulse), .RECEIVER_POWER_DOWN(p_rxpd),
        .TRANSMIT_TEST_PATTERN_SELECT(p_pattern), .JITTER_ATTENUATOR_CONFIG(p_jit), .MONITOR_GAIN_SELECT(p_mon),
        .LOOPBACK_SELECT(p_loop), .DRIVER_HIGH_IMPEDANCE(p_hiz), .RECEIVE_CLOCK_EDGE_SELECT(p_rclk),
        .ADDR(addr), .WR_DATA(wr_data), .WR_STROBE(wr_strobe), .RD_STROBE(rd_strobe), .RD_DATA(rd_data),
        .IF_HARDWARE(outs[30]), .IF_SERIAL(outs[29]), .IF_PARALLEL_A(outs[28]), .IF_PARALLEL_B(outs[27]),
        .TERM_INTERNAL(outs[26]), .PATH_SINGLE_RAIL(outs[25]), .PATH_HDB3(outs[24]),
        .PATH_CLOCK_RECOVERY(outs[23]), .PATH_SLICER(outs[22]), .TEMPLATE_120_OHM(outs[21]),
        .RX_POWERED_DOWN(outs[20]), .TX_SEND_ALL_ONES(outs[19]), .TX_SEND_PRBS(outs[18]),
        .TX_POWERED_DOWN(outs[17]), .JITTER_ENABLE(outs[16]), .JITTER_IN_TX_PATH(outs[15]),
        .JITTER_NARROW_BW(outs[14]), .JITTER_FIFO_DEPTH(outs[13:6]), .MONITOR_GAIN_HIGH(outs[5]),
        .LOOP_ANALOG(outs[4]), .LOOP_DIGITAL(outs[3]), .LOOP_REMOTE(outs[2]), .TX_DRIVER_ENABLE(outs[1]),
        .RX_CLK_FALLING(outs[0]));

    // ----------------------------------------------------------------------
    // Expected decoded outputs for a mode and a configuration word.
    // ----------------------------------------------------------------------
    function automatic logic [30:0] exp_out(input logic [1:0] m, input logic [13:0] w);
        logic [7:0] d;
        d = (w[8:7] == 2'h0) ? 8'h00 : ((w[8:7] == 2'h1) ? 8'h40 : 8'h80);
        return {m == 2'h0, m == 2'h1, m == 2'h2, m == 2'h3, w[2], ~w[1], w[1:0] == 2'h0, w[1:0] == 2'h2,
            w[1:0] == 2'h3, w[3], w[4], w[6:5] == 2'h1, w[6:5] == 2'h2, w[6:5] == 2'h3, w[8:7] != 2'h0,
            w[8:7] == 2'h3, w[8], d, w[9], w[11:10] == 2'h1, w[11:10] == 2'h2, w[11:10] == 2'h3, ~w[12], w[13]};
    endfunction

    // ----------------------------------------------------------------------
    // Bus, pin and compare tasks.
    // ----------------------------------------------------------------------
    task automatic chk_out(input logic [30:0] exp);
        n_checks++;
        if (outs !== exp) begin
            err_count++;
            $display("[ERR] %0t outputs %h expected %h", $time, outs, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        n_checks++;
        if (rd_data !== exp) begin
            err_count++;
            $display("[ERR] %0t read at %h gave %h expected %h", $time, a, rd_data, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        @(negedge ref_clk);
        chk_reg(a, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic pins(input logic [1:0] m, input logic [13:0] w);
        @(posedge ref_clk);
        mode <= m;
        word <= w;
        settle(3);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("[ERR] %0t run did not finish in time", $time);
            finish_test();
        end
    end

    // ----------------------------------------------------------------------
    // Test sequence.
    // ----------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        settle(4);
        chk_out(exp_out(2'h0, 14'h0000));
        for (int i = 0; i < 4; i++) begin
            logic [1:0] k;
            k = 2'(i);
            c = {k[1], k[0], k, k[1], k, k, k[0], k[1], k[0], k};
            pins(2'h0, c);
            chk_out(exp_out(2'h0, c));
        end
        $display("test hardware field decoding done");
        wr(8'h04, 32'h00000008);
        rd_chk(8'h04, {14'h0000, c, 4'h4});
        c = 14'h0123;
        pins(2'h0, c);
        rd_chk(8'h04, {14'h0000, c, 4'hc});
        rd_chk(8'h08, {16'h0000, 2'h0, c});
        wr(8'h08, 32'h0000ffff);
        rd_chk(8'h08, {16'h0000, 2'h0, c});
        wr(8'h04, 32'h00000008);
        rd_chk(8'h04, {14'h0000, c, 4'h4});
        rd_chk(8'h0c, 32'h00000000);
        $display("test status and strap registers done");
        pins(2'h1, c);
        chk_out(exp_out(2'h1, ctrl));
        wr(8'h00, 32'h00002abc);
        ctrl = 14'h2abc;
        settle(2);
        chk_out(exp_out(2'h1, ctrl));
        rd_chk(8'h00, {18'h00000, ctrl});
        wr(8'h04, 32'h00000008);
        rd_chk(8'h04, {14'h0000, ctrl, 4'h1});
        pins(2'h1, ~c);
        chk_out(exp_out(2'h1, ctrl));
        rd_chk(8'h04, {14'h0000, ctrl, 4'h1});
        $display("test serial mode control done");
        @(posedge ref_clk);
        rstn <= 1'b0;
        settle(2);
        chk_out(31'h0);
        @(posedge ref_clk);
        rstn <= 1'b1;
        ctrl = 14'h1000;
        settle(3);
        chk_out(exp_out(2'h1, ctrl));
        rd_chk(8'h00, {18'h00000, ctrl});
        $display("test mid-run reset done");
        for (int m = 2; m < 4; m++) begin
            pins(2'(m), c);
            chk_out(exp_out(2'(m), ctrl));
        end
        pins(2'h0, c);
        chk_out(exp_out(2'h0, c));
        $display("test interface modes done");
        finish_test();
    end
endmodule
